// ===== bcs_params.svh
// Constants for the bus cycle control store sequencer
// Summary of operation
// - Store holds 16 pages of 32 48-bit words
// - Encoder page drives address bits 8 to 5
// - Store next-address field gives bits 4 to 2
// - Condition mux supplies address bits 1 to 0
// - Page exit clears microword, control outputs and decoded strobes
// - Gate-array function selects one of four targets
// - Continue bit sampled at T20 keeps running
// - Tag-update output permits tag store rewrite
// - Two wait outputs arm oscillator restart
// - Cycle-code latch opens T0, captures T20
// - Read strobe retimed T50; separate write strobe
// - Test bit enables sync and X-to-Y path
// - Cache write enable and both-bytes select
// - Byte-select end at T20 disables selects
// - Low and high byte selects retimed T50
// - Flush-count bit increments flush counter once
// - Error-load at T50 loads error register
// - Three-bit strobe code decodes seven strobes; code 7 drives none
// - Dedicated parallel memory write data strobe
// - Hit-sample captures comparator; interrupt acknowledge
// - Gate-array enable drives internal X bus
// - Select code zero passes default branch bits
// - Armed wait plus reply restarts oscillator
`ifndef BCS_PARAMS_SVH
`define BCS_PARAMS_SVH
`define BCS_PAGE_W      4
`define BCS_MID_W       3
`define BCS_LOW_W       2
`define BCS_WORD_W      48
`define BCS_HI_W        16
`define BCS_COND_W      16
`define BCS_ERR_W       16
`define BCS_GP_N        7
`define BCS_GA_N        4
`define BCS_PH_T0       3'h0
`define BCS_PH_T10      3'h1
`define BCS_PH_T40      3'h4
`define BCS_PH_T50      3'h5
`define BCS_PH_FETCH    3'h6
`define BCS_SEL_DEFAULT 3'h0
`define BCS_GP_STALL    3'h5
`define BCS_OFF_CTRL    12'h000
`define BCS_OFF_STATUS  12'h004
`define BCS_OFF_SADDR   12'h008
`define BCS_OFF_SLO     12'h00C
`define BCS_OFF_SHI     12'h010
`define BCS_OFF_FLUSH   12'h014
`define BCS_OFF_ERROR   12'h018
`define BCS_CTRL_RUN    0
`define BCS_CTRL_RST    1'h0
`define BCS_PHASE_DIV   2
`define BCS_FLUSH_W     8
`endif

// ===== bcs_pkg.sv
// Types shared by the control store sequencer
`include "bcs_params.svh"
package bcs_pkg;

  typedef enum logic [1:0] {
    BCS_IDLE = 2'b00,
    BCS_RUN  = 2'b01,
    BCS_WAIT = 2'b10
  } bcs_state_t;

  typedef struct packed {
    logic [`BCS_MID_W-1:0] seq_addr_mid;
    logic [`BCS_LOW_W-1:0] default_branch_bits;
    logic [2:0]            cond_mux_select;
    logic [1:0]            gate_array_function;
    logic                  osc_continue;
    logic                  tag_update;
    logic                  gate_array_x_en;
    logic                  wait_no_reply;
    logic                  wait_reply;
    logic                  cycle_code_latch;
    logic                  read_strobe_out;
    logic                  write_strobe_out;
    logic                  sysbus_sync_test;
    logic                  cache_write_en;
    logic                  cache_both_bytes;
    logic                  byte_select_end;
    logic                  cache_low_byte_sel;
    logic                  cache_high_byte_sel;
    logic                  flush_count_inc;
    logic                  error_reg_load;
    logic [2:0]            gp_strobe_code;
    logic                  pmi_write_strobe;
    logic                  hit_sample;
    logic                  irq_acknowledge;
    logic [15:0]           spare;
  } bcs_uword_t;

  typedef struct packed {
    logic [`BCS_PAGE_W-1:0] cycle_code;
    logic                   osc_start;
    logic [`BCS_COND_W-1:0] cond;
    logic                   received_reply;
    logic                   cached_reply;
    logic                   no_reply;
    logic                   stall;
    logic                   dma_tag_match;
    logic [`BCS_ERR_W-1:0]  err_status;
  } bcs_in_t;

  typedef struct packed {
    logic tag_update;
    logic gate_array_x_en;
    logic cycle_code_latch;
    logic dati_strobe;
    logic dato_strobe;
    logic sysbus_sync;
    logic x_to_y_path;
    logic cache_write_en;
    logic cache_both_bytes;
    logic byte_select_end;
    logic cache_low_byte_sel;
    logic cache_high_byte_sel;
    logic flush_count_inc;
    logic error_reg_load;
    logic pmi_write_strobe;
    logic hit_sample;
    logic irq_acknowledge;
    logic wait_reply;
    logic wait_no_reply;
    logic osc_run;
  } bcs_ctl_t;

endpackage

// ===== bcs_store.sv
// Control store memory with registered read data
`timescale 1ns/100ps
module bcs_store #(
  parameter int AW = 9,
  parameter int DW = 48
) (
  input  wire logic          clk_i,
  input  wire logic          rst_b_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);

  if (AW < 1 || DW < 1) begin : g_size_chk
    $error("AW and DW must be positive");
  end

  logic [DW-1:0] mem_q [2**AW];

  // Write port
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  // Registered read port
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem_q[raddr_i];
    end
  end

endmodule // bcs_store

// ===== bcs_sequencer.sv
// Microprogrammed bus cycle sequencer with APB access to its store
`timescale 1ns/100ps
`include "bcs_params.svh"
module bcs_sequencer
  import bcs_pkg::*;
#(
  parameter int PHASE_DIV = `BCS_PHASE_DIV,
  parameter int FLUSH_W   = `BCS_FLUSH_W
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [11:0]            paddr_i,
  input  wire logic [31:0]            pwdata_i,
  output logic      [31:0]            prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  input  wire bcs_in_t                async_i,
  output bcs_ctl_t                    ctl_o,
  output logic      [`BCS_GP_N-1:0]   gp_strobe_o,
  output logic      [`BCS_GA_N-1:0]   ga_target_o,
  output logic      [FLUSH_W-1:0]     flush_count_o,
  output logic      [`BCS_ERR_W-1:0]  error_reg_o
);

  localparam int AW    = `BCS_PAGE_W + `BCS_MID_W + `BCS_LOW_W;
  localparam int DIV_W = (PHASE_DIV < 2) ? 1 : $clog2(PHASE_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PHASE_DIV - 1);

  if (PHASE_DIV < 2) begin : g_div_chk
    $error("PHASE_DIV must be at least 2");
  end
  if (FLUSH_W < 1 || FLUSH_W > 32) begin : g_flush_chk
    $error("FLUSH_W must lie in 1 to 32");
  end

  bcs_in_t                 sync1_q;
  bcs_in_t                 in_q;
  bcs_state_t              state_q;
  bcs_state_t              state_d;
  bcs_uword_t              uw_q;
  bcs_uword_t              rd_word;
  bcs_ctl_t                ctl_q;
  logic [DIV_W-1:0]        div_q;
  logic [2:0]              phase_q;
  logic [`BCS_PAGE_W-1:0]  page_q;
  logic [`BCS_PAGE_W-1:0]  cyc_q;
  logic [`BCS_MID_W-1:0]   mid_q;
  logic [`BCS_LOW_W-1:0]   low_q;
  logic [`BCS_LOW_W-1:0]   mux_bits;
  logic [AW-1:0]           uaddr;
  logic [`BCS_WORD_W-1:0]  rdata;
  logic [`BCS_GP_N-1:0]    gp_q;
  logic [`BCS_GA_N-1:0]    ga_q;
  logic                    tick;
  logic                    running;
  logic                    go_t0;
  logic                    go_t20;
  logic                    go_t50;
  logic                    step_end;
  logic                    leave;
  logic                    restart;
  logic                    cont_q;
  logic                    stall_arm_q;
  logic                    hit_q;
  logic                    run_en_q;
  logic [AW-1:0]           saddr_q;
  logic [31:0]             slo_q;
  logic [`BCS_HI_W-1:0]    shi_q;
  logic [FLUSH_W-1:0]      flush_q;
  logic [`BCS_ERR_W-1:0]   err_q;
  logic                    setup;
  logic                    wr_acc;
  logic                    store_we;
  logic                    flush_clr;
  logic                    flush_inc;
  logic                    addr_hit;
  logic [31:0]             rd_mux;

  // Two-stage synchroniser for all partner inputs
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_q <= '0;
      in_q    <= '0;
    end else begin
      sync1_q <= async_i;
      in_q    <= sync1_q;
    end
  end

  // Phase tap divider
  assign tick = (div_q == DIV_LAST);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q <= '0;
    end else if (tick || (state_q == BCS_WAIT && state_d == BCS_RUN)) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  assign running  = (state_q == BCS_RUN);
  assign go_t0    = running && tick && (phase_q == `BCS_PH_FETCH);
  assign go_t20   = running && tick && (phase_q == `BCS_PH_T10);
  assign go_t50   = running && tick && (phase_q == `BCS_PH_T40);
  assign step_end = running && tick && (phase_q == `BCS_PH_T50);
  assign rd_word  = bcs_uword_t'(rdata);

  assign restart = (ctl_q.wait_reply && (in_q.received_reply || in_q.cached_reply))
                || (ctl_q.wait_no_reply && in_q.no_reply)
                || (stall_arm_q && in_q.stall);

  always_comb begin
    mux_bits = in_q.cond[{uw_q.cond_mux_select, 1'b0} +: `BCS_LOW_W];
    if (uw_q.cond_mux_select == `BCS_SEL_DEFAULT) begin
      mux_bits = uw_q.default_branch_bits;
    end
  end

  // Oscillator run control
  always_comb begin
    state_d = state_q;
    case (state_q)
      BCS_IDLE: begin
        if (run_en_q && in_q.osc_start && tick) begin
          state_d = BCS_RUN;
        end
      end
      BCS_RUN: begin
        if (step_end) begin
          if (!run_en_q) begin
            state_d = BCS_IDLE;
          end else if (cont_q) begin
            state_d = BCS_RUN;
          end else if (ctl_q.wait_reply || ctl_q.wait_no_reply || stall_arm_q) begin
            state_d = BCS_WAIT;
          end else begin
            state_d = BCS_IDLE;
          end
        end
      end
      BCS_WAIT: begin
        if (!run_en_q) begin
          state_d = BCS_IDLE;
        end else if (restart) begin
          state_d = BCS_RUN;
        end
      end
      default: begin
        state_d = BCS_IDLE;
      end
    endcase
  end

  assign leave = (state_q != BCS_IDLE) && (state_d == BCS_IDLE);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= BCS_IDLE;
      phase_q <= `BCS_PH_FETCH;
      page_q  <= '0;
      mid_q   <= '0;
      low_q   <= '0;
    end else begin
      state_q <= state_d;
      if (state_q == BCS_IDLE && state_d == BCS_RUN) begin
        page_q  <= in_q.cycle_code;
        mid_q   <= '0;
        low_q   <= '0;
        phase_q <= `BCS_PH_FETCH;
      end else if (running && tick) begin
        if (phase_q == `BCS_PH_T50) begin
          mid_q   <= uw_q.seq_addr_mid;
          low_q   <= mux_bits;
          phase_q <= `BCS_PH_FETCH;
        end else if (phase_q == `BCS_PH_FETCH) begin
          phase_q <= `BCS_PH_T0;
        end else begin
          phase_q <= phase_q + 3'h1;
        end
      end
    end
  end

  assign uaddr = {page_q, mid_q, low_q};

  // Microword outputs on phase taps
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      uw_q        <= '0;
      ctl_q       <= '0;
      cont_q      <= 1'b0;
      stall_arm_q <= 1'b0;
      hit_q       <= 1'b0;
      cyc_q       <= '0;
    end else if (leave) begin
      uw_q        <= '0;
      ctl_q       <= '0;
      cont_q      <= 1'b0;
      stall_arm_q <= 1'b0;
    end else begin
      ctl_q.osc_run <= (state_d == BCS_RUN);
      if (state_q == BCS_WAIT && restart) begin
        ctl_q.wait_reply    <= 1'b0;
        ctl_q.wait_no_reply <= 1'b0;
        stall_arm_q         <= 1'b0;
      end
      if (go_t0) begin
        uw_q                   <= rd_word;
        ctl_q.tag_update       <= rd_word.tag_update;
        ctl_q.gate_array_x_en  <= rd_word.gate_array_x_en;
        ctl_q.cycle_code_latch <= rd_word.cycle_code_latch;
        ctl_q.dato_strobe      <= rd_word.write_strobe_out;
        ctl_q.dati_strobe      <= 1'b0;
        ctl_q.sysbus_sync      <= rd_word.sysbus_sync_test;
        ctl_q.x_to_y_path      <= rd_word.sysbus_sync_test;
        ctl_q.cache_write_en   <= rd_word.cache_write_en;
        ctl_q.cache_both_bytes <= rd_word.cache_both_bytes;
        ctl_q.flush_count_inc  <= rd_word.flush_count_inc;
        ctl_q.error_reg_load   <= 1'b0;
        ctl_q.pmi_write_strobe <= rd_word.pmi_write_strobe;
        ctl_q.hit_sample       <= rd_word.hit_sample;
        ctl_q.irq_acknowledge  <= rd_word.irq_acknowledge;
        if (rd_word.hit_sample) begin
          hit_q <= in_q.dma_tag_match;
        end
        ctl_q.wait_reply       <= rd_word.wait_reply;
        ctl_q.wait_no_reply    <= rd_word.wait_no_reply;
        stall_arm_q            <= (rd_word.gp_strobe_code == `BCS_GP_STALL);
      end
      if (go_t20) begin
        cont_q                 <= uw_q.osc_continue;
        ctl_q.cycle_code_latch <= 1'b0;
        if (uw_q.cycle_code_latch) begin
          cyc_q <= in_q.cycle_code;
        end
        ctl_q.byte_select_end  <= uw_q.byte_select_end;
        if (uw_q.byte_select_end) begin
          ctl_q.cache_low_byte_sel  <= 1'b0;
          ctl_q.cache_high_byte_sel <= 1'b0;
        end
      end
      if (go_t50) begin
        ctl_q.dati_strobe         <= uw_q.read_strobe_out;
        ctl_q.cache_low_byte_sel  <= uw_q.cache_low_byte_sel;
        ctl_q.cache_high_byte_sel <= uw_q.cache_high_byte_sel;
        ctl_q.error_reg_load      <= uw_q.error_reg_load;
      end
    end
  end

  // Strobe and gate-array target decode
  for (genvar i = 0; i < `BCS_GP_N; i++) begin : g_dec
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        gp_q[i] <= 1'b0;
      end else if (leave) begin
        gp_q[i] <= 1'b0;
      end else if (go_t0) begin
        gp_q[i] <= (rd_word.gp_strobe_code == 3'(i));
      end
    end
    if (i < `BCS_GA_N) begin : g_ga
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          ga_q[i] <= 1'b0;
        end else if (leave) begin
          ga_q[i] <= 1'b0;
        end else if (go_t0) begin
          ga_q[i] <= (rd_word.gate_array_function == 2'(i));
        end
      end
    end
  end

  assign flush_inc = go_t0 && rd_word.flush_count_inc;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flush_q <= '0;
    end else begin
      flush_q <= (flush_clr ? '0 : flush_q) + {{(FLUSH_W-1){1'b0}}, flush_inc};
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      err_q <= '0;
    end else if (go_t50 && uw_q.error_reg_load) begin
      err_q <= in_q.err_status;
    end
  end

  // APB slave, zero wait states
  assign setup     = psel_i && !penable_i;
  assign wr_acc    = psel_i && penable_i && pwrite_i;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !addr_hit;
  assign flush_clr = wr_acc && (paddr_i == `BCS_OFF_FLUSH);
  assign store_we  = wr_acc && (paddr_i == `BCS_OFF_SHI) && !run_en_q && (state_q == BCS_IDLE);

  always_comb begin
    addr_hit = 1'b1;
    rd_mux   = 32'h0000_0000;
    case (paddr_i)
      `BCS_OFF_CTRL:   rd_mux = 32'(run_en_q);
      `BCS_OFF_STATUS: rd_mux = 32'({hit_q, cont_q, cyc_q, uaddr, phase_q, state_q});
      `BCS_OFF_SADDR:  rd_mux = 32'(saddr_q);
      `BCS_OFF_SLO:    rd_mux = slo_q;
      `BCS_OFF_SHI:    rd_mux = 32'(shi_q);
      `BCS_OFF_FLUSH:  rd_mux = 32'(flush_q);
      `BCS_OFF_ERROR:  rd_mux = 32'(err_q);
      default:         addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (setup && !pwrite_i) begin
      prdata_o <= rd_mux;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_en_q <= `BCS_CTRL_RST;
      saddr_q  <= '0;
      slo_q    <= 32'h0000_0000;
      shi_q    <= '0;
    end else if (wr_acc) begin
      case (paddr_i)
        `BCS_OFF_CTRL:  run_en_q <= pwdata_i[`BCS_CTRL_RUN];
        `BCS_OFF_SADDR: saddr_q  <= pwdata_i[AW-1:0];
        `BCS_OFF_SLO:   slo_q    <= pwdata_i;
        `BCS_OFF_SHI: begin
          shi_q <= pwdata_i[`BCS_HI_W-1:0];
          if (store_we) begin
            saddr_q <= saddr_q + 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  bcs_store #(
    .AW (AW),
    .DW (`BCS_WORD_W)
  ) u_store (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .we_i    (store_we),
    .waddr_i (saddr_q),
    .wdata_i ({pwdata_i[`BCS_HI_W-1:0], slo_q}),
    .raddr_i (uaddr),
    .rdata_o (rdata)
  );

  assign ctl_o         = ctl_q;
  assign gp_strobe_o   = gp_q;
  assign ga_target_o   = ga_q;
  assign flush_count_o = flush_q;
  assign error_reg_o   = err_q;

endmodule // bcs_sequencer

// ===== bcs_sequencer_sva.sv
// Assertion checker for the control store sequencer
`timescale 1ns/100ps
`include "bcs_params.svh"
module bcs_sequencer_sva
  import bcs_pkg::*;
#(
  parameter int PHASE_DIV = `BCS_PHASE_DIV,
  parameter int FLUSH_W   = `BCS_FLUSH_W
) (
  input wire logic                  clk_i,
  input wire logic                  rst_b_i,
  input wire logic                  psel_i,
  input wire logic                  penable_i,
  input wire logic                  pwrite_i,
  input wire logic [11:0]           paddr_i,
  input wire bcs_ctl_t              ctl_o,
  input wire logic [`BCS_GP_N-1:0]  gp_strobe_o,
  input wire logic [`BCS_GA_N-1:0]  ga_target_o,
  input wire logic [FLUSH_W-1:0]    flush_count_o,
  input wire logic [`BCS_ERR_W-1:0] error_reg_o
);
  logic [7:0] ph_q;
  logic       wfl_q;
  logic       wer_q;

  // Clock count inside the current step
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ph_q <= 8'h00;
    end else if (!ctl_o.osc_run || ph_q == 8'(7 * PHASE_DIV - 1)) begin
      ph_q <= 8'h00;
    end else begin
      ph_q <= ph_q + 8'h01;
    end
  end

  // Software writes to the counting registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wfl_q <= 1'b0;
      wer_q <= 1'b0;
    end else begin
      wfl_q <= psel_i && penable_i && pwrite_i && paddr_i == `BCS_OFF_FLUSH;
      wer_q <= psel_i && penable_i && pwrite_i && paddr_i == `BCS_OFF_ERROR;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_gp_onehot: assert property (
    $onehot0(gp_strobe_o)) else $error("strobe decode not one-hot");
  a_gp_at_t0: assert property (
    ctl_o.osc_run && $changed(gp_strobe_o) |-> ph_q == PHASE_DIV) else $error("strobe changed off T0");
  a_ga_onehot: assert property (
    $onehot0(ga_target_o)) else $error("gate-array target not one-hot");
  a_flush_step: assert property (
    $changed(flush_count_o) && !wfl_q |-> flush_count_o == $past(flush_count_o) + 1'b1 && ph_q == PHASE_DIV)
    else $error("flush counter jump");
  a_latch_open: assert property (
    $rose(ctl_o.cycle_code_latch) |-> ph_q == PHASE_DIV) else $error("latch opened off T0");
  a_latch_close: assert property (
    $fell(ctl_o.cycle_code_latch) && ctl_o.osc_run |-> ph_q == 3 * PHASE_DIV) else $error("latch closed off T20");
  a_dati_t50: assert property (
    $rose(ctl_o.dati_strobe) |-> ph_q == 6 * PHASE_DIV && !ctl_o.cycle_code_latch) else $error("read strobe off T50");
  a_sel_t50: assert property (
    $rose(ctl_o.cache_low_byte_sel) || $rose(ctl_o.cache_high_byte_sel) |-> ph_q == 6 * PHASE_DIV)
    else $error("byte select off T50");
  a_err_t50: assert property (
    $changed(error_reg_o) && !wer_q |-> ctl_o.error_reg_load && ph_q == 6 * PHASE_DIV)
    else $error("error register loaded off T50");
  a_end_clears: assert property (
    $rose(ctl_o.byte_select_end) |-> !ctl_o.cache_low_byte_sel && !ctl_o.cache_high_byte_sel && ph_q == 3 * PHASE_DIV)
    else $error("byte selects not cleared at T20");

  c_dati: cover property ($rose(ctl_o.dati_strobe));
  c_flush: cover property ($changed(flush_count_o));
  c_wait: cover property ($fell(ctl_o.osc_run) ##[1:40] $rose(ctl_o.osc_run));
endmodule // bcs_sequencer_sva

bind bcs_sequencer bcs_sequencer_sva #(.PHASE_DIV(PHASE_DIV), .FLUSH_W(FLUSH_W)) u_bcs_sequencer_sva (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .ctl_o(ctl_o), .gp_strobe_o(gp_strobe_o), .ga_target_o(ga_target_o),
  .flush_count_o(flush_count_o), .error_reg_o(error_reg_o));

// ===== bcs_partner.sv
// Far-side model: cycle encoder, oscillator start and bus replies
`timescale 1ns/100ps
module bcs_partner
  import bcs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        go_i,
  input  wire logic [3:0]  page_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic [15:0] cond_i,
  input  wire logic [15:0] err_i,
  input  wire bcs_ctl_t    ctl_i,
  output bcs_in_t          async_o
);
  logic       start_q;
  logic       armed_q;
  logic [3:0] wait_q;
  logic       reply;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      start_q <= 1'b0;
    end else if (go_i) begin
      start_q <= 1'b1;
    end else if (ctl_i.osc_run) begin
      start_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      armed_q <= 1'b0;
      wait_q  <= 4'h0;
    end else if (ctl_i.osc_run) begin
      armed_q <= ctl_i.wait_reply | ctl_i.wait_no_reply;
      wait_q  <= 4'h0;
    end else if (armed_q && wait_q != 4'hF) begin
      wait_q <= wait_q + 4'h1;
    end
  end

  assign reply = armed_q && !ctl_i.osc_run && wait_q >= 4'h6;

  always_comb begin
    async_o                = '0;
    async_o.cycle_code     = page_i;
    async_o.osc_start      = start_q;
    async_o.cond           = cond_i;
    async_o.received_reply = reply && mode_i == 2'h0;
    async_o.cached_reply   = reply && mode_i == 2'h1;
    async_o.no_reply       = reply && mode_i == 2'h2;
    async_o.err_status     = err_i;
  end
endmodule // bcs_partner

// ===== bcs_sequencer_bench.sv
// Self-checking bench for the control store sequencer
`timescale 1ns/100ps
module bcs_sequencer_bench
  import bcs_pkg::*;
;
  localparam int PD = 2;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, er, go;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  page, ga;
  logic [1:0]  mode;
  logic [15:0] cond, errs, err;
  logic [6:0]  gp;
  logic [7:0]  flush;
  bcs_in_t     async;
  bcs_ctl_t    ctl;
  bcs_uword_t  w;
  int          n_fail, checks;
  logic [1:0]  lo [8] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h2, 2'h0, 2'h0};
  logic [9:0]  ex [8] = '{10'h001, 10'h002, 10'h00C, 10'h030, 10'h040, 10'h180, 10'h200, 10'h000};

  bcs_sequencer #(.PHASE_DIV(PD), .FLUSH_W(8)) u_bcs_sequencer (
    .clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .async_i(async), .ctl_o(ctl), .gp_strobe_o(gp), .ga_target_o(ga), .flush_count_o(flush),
    .error_reg_o(err));
  bcs_partner u_bcs_partner (
    .clk_i(clk), .rst_b_i(rst_b), .go_i(go), .page_i(page), .mode_i(mode), .cond_i(cond),
    .err_i(errs), .ctl_i(ctl), .async_o(async));

  always #20 clk = ~clk;

  task automatic give_verdict;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 16);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 16) begin chk(32'(pready), 32'h1); give_verdict; end
  endtask

  task automatic ld(input logic [8:0] a, input bcs_uword_t v);
    apb(1'b1, 12'h008, {23'h0, a});
    apb(1'b1, 12'h00C, v[31:0]);
    apb(1'b1, 12'h010, {16'h0, v[47:32]});
  endtask

  task automatic nclk(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wrun(input logic v);
    int n;
    n = 0;
    while (ctl.osc_run !== v && n < 400) begin @(negedge clk); n++; end
    if (n >= 400) begin chk(32'(ctl.osc_run), 32'(v)); give_verdict; end
  endtask

  task automatic start(input logic [3:0] p);
    @(posedge clk);
    page <= p; go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    wrun(1'b1);
  endtask

  function automatic logic [9:0] imm(input bcs_ctl_t c);
    return {c.dato_strobe, c.irq_acknowledge, c.hit_sample, c.pmi_write_strobe, c.x_to_y_path,
            c.sysbus_sync, c.cache_both_bytes, c.cache_write_en, c.gate_array_x_en, c.tag_update};
  endfunction

  initial begin
    clk = 1'b0; rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; go = 1'b0; page = 4'h0; mode = 2'h0; cond = 16'h0040; errs = 16'hA5C3;
    n_fail = 0; checks = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h0);
    apb(1'b0, 12'h014, 32'h0); chk(rd, 32'h0);
    apb(1'b0, 12'h018, 32'h0); chk(rd, 32'h0);
    apb(1'b0, 12'h01C, 32'h0); chk(rd, 32'h0);
    chk(32'(er), 32'h1);
    $display("registers test done");
    for (int j = 0; j < 8; j++) begin
      w = '0;
      w.seq_addr_mid = 3'(j + 1);
      w.default_branch_bits = (j == 4) ? 2'h2 : 2'h0;
      w.cond_mux_select = (j == 2) ? 3'h3 : 3'h0;
      w.gate_array_function = 2'(j);
      w.gp_strobe_code = 3'(j);
      w.osc_continue = j < 7;
      w.cycle_code_latch = 1'b1;
      w.flush_count_inc = 1'b1;
      w.tag_update = j == 0;
      w.gate_array_x_en = j == 1;
      w.cache_write_en = j == 2;
      w.cache_both_bytes = j == 2;
      w.sysbus_sync_test = j == 3;
      w.pmi_write_strobe = j == 4;
      {w.read_strobe_out, w.cache_low_byte_sel, w.cache_high_byte_sel} = {3{j == 5}};
      {w.error_reg_load, w.hit_sample, w.irq_acknowledge} = {3{j == 5}};
      w.byte_select_end = j == 6;
      w.write_strobe_out = j == 6;
      ld({4'h9, 3'(j), lo[j]}, w);
    end
    apb(1'b1, 12'h000, 32'h1);
    start(4'h9);
    for (int j = 0; j < 8; j++) begin
      nclk(PD);
      chk(32'(gp), (j < 7) ? 32'(1 << j) : 32'h0);
      chk(32'(ga), 32'(1 << (j % 4)));
      chk(32'(flush), 32'(j + 1));
      chk(32'(imm(ctl)), 32'(ex[j]));
      chk(32'({ctl.cycle_code_latch, ctl.osc_run, ctl.cache_low_byte_sel, ctl.cache_high_byte_sel}),
          (j == 6) ? 32'hF : 32'hC);
      nclk(2 * PD);
      chk(32'({ctl.cycle_code_latch, ctl.byte_select_end, ctl.cache_low_byte_sel, ctl.cache_high_byte_sel}),
          (j == 6) ? 32'h4 : 32'h0);
      nclk(3 * PD);
      chk(32'({ctl.dati_strobe, ctl.cache_low_byte_sel, ctl.error_reg_load}), (j == 5) ? 32'h7 : 32'h0);
      chk(32'(err), (j >= 5) ? 32'hA5C3 : 32'h0);
      nclk(PD);
    end
    chk(32'({ctl, gp, ga}), 32'h0);
    apb(1'b0, 12'h008, 32'h0); chk(rd, 32'h13D);
    apb(1'b0, 12'h014, 32'h0); chk(rd, 32'h8);
    apb(1'b1, 12'h014, 32'h0);
    apb(1'b0, 12'h014, 32'h0); chk(rd, 32'h0);
    $display("page walk test done");
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, 12'h000, 32'h0);
      w = '0;
      w.seq_addr_mid = 3'h1;
      w.wait_reply = m < 2;
      w.wait_no_reply = m == 2;
      ld(9'h040, w);
      w = '0;
      w.gp_strobe_code = 3'h7;
      ld(9'h044, w);
      mode <= 2'(m);
      apb(1'b1, 12'h000, 32'h1);
      start(4'h2);
      wrun(1'b0);
      nclk(6);
      chk(32'(ctl.osc_run), 32'h0);
      wrun(1'b1);
      wrun(1'b0);
      chk(32'({ctl, gp, ga}), 32'h0);
    end
    $display("wait restart test done");
    give_verdict;
  end
endmodule // bcs_sequencer_bench
